// [core/ppdc_pkg.sv]
/*
 Constants, field positions and types for the palette access port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ppdc_pkg;
	localparam logic [7:0] IO_PAGE = 8'h21;
	localparam logic [3:0] OFF_INDEX = 4'hA;
	localparam logic [3:0] OFF_DATA_FIRST = 4'hB;
	localparam logic [7:0] BANK_BASE = 8'h50;
	localparam logic [7:0] BANK_LAST = 8'h6F;
	localparam logic [7:0] IDX_DRAW_CTRL = 8'h50;
	localparam logic [7:0] IDX_BORDER = 8'h55;
	localparam logic [7:0] IDX_DIRECT_CTRL = 8'h59;
	localparam logic [7:0] IDX_INDEX_LO = 8'h60;
	localparam logic [7:0] IDX_INDEX_HI = 8'h61;
	localparam logic [7:0] IDX_PF_LO = 8'h62;
	localparam logic [7:0] IDX_PF_HI = 8'h63;
	localparam logic [7:0] IDX_PAL_MASK = 8'h64;
	localparam logic [7:0] IDX_PAL_DATA = 8'h65;
	localparam logic [7:0] IDX_SEQUENCE = 8'h66;
	localparam logic [7:0] IDX_RED_HOLD = 8'h67;
	localparam logic [7:0] IDX_GREEN_HOLD = 8'h68;
	localparam logic [7:0] IDX_BLUE_HOLD = 8'h69;
	localparam logic [7:0] IDX_SPRITE_HOLD = 8'h6B;
	localparam logic [7:0] IDX_MISC_CTRL = 8'h6C;
	localparam int SEQ_ORDER_BIT = 2;
	localparam int DIRECT_EN_BIT = 2;
	localparam int FILL_LSB = 0;
	localparam int BLANK_RB_BIT = 0;
	localparam int DRAW_WIDE_BIT = 0;
	localparam int BORDER_HALF_BIT = 7;
	localparam int RED_BITS = 5;
	localparam int GREEN_BITS = 6;
	localparam int BLUE_BITS = 5;
	localparam int LANES = 4;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	typedef enum logic [1:0] {
		SLOT_RED = 2'b00,
		SLOT_GREEN = 2'b01,
		SLOT_BLUE = 2'b10,
		SLOT_SKIP = 2'b11
	} ppdc_slot_t;
	typedef enum logic [1:0] {
		FILL_ZERO = 2'b00,
		FILL_ONE = 2'b01,
		FILL_LINEAR = 2'b10,
		FILL_NONZERO = 2'b11
	} ppdc_fill_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LANE = 2'b01
	} ppdc_state_t;
endpackage

// [core/ppdc_dac_fill.sv]
/*
 Colour output stage: palette colour or 16-bit direct colour onto
 8-bit converter inputs. Assumes pixel and palette data on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ppdc_dac_fill #(
	parameter bit ENHANCED = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_direct,
	input wire logic [15:0] i_pixel,
	input wire logic [23:0] i_pal_rgb,
	input wire logic [1:0] i_fill,
	input wire logic i_blank_rb,
	output logic [7:0] o_red,
	output logic [7:0] o_green,
	output logic [7:0] o_blue
);
	import ppdc_pkg::*;

	function automatic logic [7:0] fill_bits(input logic [7:0] v, input int n,
			input logic [1:0] m);
		logic [7:0] r;
		r = v;
		for (int i = 0; i < 8; i++) begin
			if (i < 8 - n) begin
				case (m)
					FILL_ZERO: r[i] = 1'b0;
					FILL_ONE: r[i] = 1'b1;
					FILL_LINEAR: r[i] = v[i + n];
					default: r[i] = |v;
				endcase
			end
		end
		return r;
	endfunction

	logic [1:0] fill_eff;
	logic [7:0] red_nxt;
	logic [7:0] green_nxt;
	logic [7:0] blue_nxt;

	always_comb begin
		// Base variant has no fill choice; undefined bits stay zero
		fill_eff = ENHANCED ? i_fill : FILL_ZERO;
		if (i_direct) begin
			red_nxt = fill_bits({i_pixel[15:11], 3'h0}, RED_BITS, fill_eff);
			green_nxt = fill_bits({i_pixel[10:5], 2'h0}, GREEN_BITS, fill_eff);
			blue_nxt = fill_bits({i_pixel[4:0], 3'h0}, BLUE_BITS, fill_eff);
		end else begin
			red_nxt = i_pal_rgb[23:16];
			green_nxt = i_pal_rgb[15:8];
			blue_nxt = i_pal_rgb[7:0];
		end
		if (ENHANCED && i_blank_rb) begin
			red_nxt = 8'h00;
			blue_nxt = 8'h00;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_red <= 8'h00;
			o_green <= 8'h00;
			o_blue <= 8'h00;
		end else if (i_ce) begin
			o_red <= red_nxt;
			o_green <= green_nxt;
			o_blue <= blue_nxt;
		end
	end

	chk_direct_msb_map: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_direct && !i_blank_rb) |=> (o_red[7:3] == $past(i_pixel[15:11])
		&& o_green[7:2] == $past(i_pixel[10:5]) && o_blue[7:3] == $past(i_pixel[4:0])))
		else $error("direct colour fields misplaced");

	chk_fill_one_low: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_direct && ENHANCED && !i_blank_rb && i_fill == FILL_ONE)
		|=> (o_red[2:0] == 3'h7 && o_green[1:0] == 2'h3))
		else $error("fill with ones not applied");
endmodule
`default_nettype wire

// [core/ppdc_top.sv]
/*
 Palette access port with indexed register bank, holding register,
 colour sequencing and direct colour output.
 Assumes host I/O requests arrive as one-cycle pulses on i_clk and
 that pixel data is produced on the same clock.
*/
// Notes on behaviour
// - Update order: red-green-blue or red-blue-green-skip
// - Palette location from low index, 256 entries
// - Data write fills sequenced field, sequence advances
// - Order one: third write commits, sequence restarts
// - Order two: fourth write commits, byte dropped
// - Prefetch index write loads holding, steps index
// - Data read returns sequenced field, then advances
// - Last field read refills holding, steps index
// - Direct 16-bit word feeds converter fields
// - Enhanced variant fills undefined bits four ways
// - Base variant draws only with 8-bit pixels
// - Narrow drawing over wide pixels works bytewise
// - Sixteen byte ports, instance digit in address
// - Index port selects, five data ports reach
// - Word write to index: index then data
// - String transfers of two or four bytes
// - Palette mask zeroes pixel bits before lookup
`timescale 1ns/10ps
`default_nettype none
module ppdc_top #(
	parameter logic [3:0] INSTANCE = 4'h6,
	parameter bit ENHANCED = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_io_req,
	input wire logic i_io_write,
	input wire logic [15:0] i_io_addr,
	input wire logic [3:0] i_io_be,
	input wire logic [31:0] i_io_wdata,
	input wire logic [15:0] i_pixel,
	output logic [31:0] o_io_rdata,
	output logic o_io_ack,
	output logic o_io_busy,
	output logic [7:0] o_red,
	output logic [7:0] o_green,
	output logic [7:0] o_blue,
	output logic o_draw_wide
);
	import ppdc_pkg::*;

	function automatic ppdc_slot_t next_slot(input ppdc_slot_t s, input logic order2);
		ppdc_slot_t n;
		n = SLOT_RED;
		if (!order2) begin
			case (s)
				SLOT_RED: n = SLOT_GREEN;
				SLOT_GREEN: n = SLOT_BLUE;
				default: n = SLOT_RED;
			endcase
		end else begin
			case (s)
				SLOT_RED: n = SLOT_BLUE;
				SLOT_BLUE: n = SLOT_GREEN;
				SLOT_GREEN: n = SLOT_SKIP;
				default: n = SLOT_RED;
			endcase
		end
		return n;
	endfunction

	function automatic logic [4:0] bank_slot(input logic [7:0] idx);
		logic [7:0] d;
		d = idx - BANK_BASE;
		return d[4:0];
	endfunction

	ppdc_state_t state_r;
	logic [1:0] lane_r;
	logic [3:0] off_r;
	logic [3:0] be_r;
	logic [31:0] wd_r;
	logic wr_r;
	logic [7:0] reg_index_r;
	logic [7:0] idx_lo_r;
	ppdc_slot_t slot_r;
	logic order2_r;
	logic [7:0] hold_r [0:2];
	logic [7:0] bank_r [0:31];
	logic [23:0] palette [0:255];
	logic [4:0] lane_addr;
	logic lane_ok;
	logic [7:0] lane_byte;
	logic is_data;
	logic ind_wr;
	logic ind_rd;
	logic pal_wr;
	logic pal_rd;
	logic pf_wr;
	logic io_hit;
	logic take;
	logic wrap;
	ppdc_slot_t slot_nxt;
	logic [7:0] hold_sel;
	logic [23:0] merged;
	logic [23:0] cur_entry;
	logic [23:0] pf_entry;
	logic [7:0] rd_byte;
	logic in_bank;
	logic [7:0] pix_addr;

	always_comb begin
		// Decode of the sixteen byte ports for this instance
		io_hit = i_io_addr[15:8] == IO_PAGE && i_io_addr[7:4] == INSTANCE;
		take = i_ce && i_io_req && state_r == ST_IDLE && io_hit;
		lane_addr = {1'b0, off_r} + {3'h0, lane_r};
		lane_ok = state_r == ST_LANE && be_r[lane_r] && !lane_addr[4];
		lane_byte = wd_r[{lane_r, 3'h0} +: 8];
		is_data = lane_addr[3:0] >= OFF_DATA_FIRST;
		ind_wr = lane_ok && wr_r && is_data;
		ind_rd = lane_ok && !wr_r && is_data;
		pal_wr = ind_wr && reg_index_r == IDX_PAL_DATA;
		pal_rd = ind_rd && reg_index_r == IDX_PAL_DATA;
		pf_wr = ind_wr && reg_index_r == IDX_PF_LO;
		in_bank = reg_index_r >= BANK_BASE && reg_index_r <= BANK_LAST;
		slot_nxt = next_slot(slot_r, order2_r);
		wrap = slot_nxt == SLOT_RED;
		cur_entry = palette[idx_lo_r];
		pf_entry = palette[lane_byte];
		hold_sel = (slot_r == SLOT_SKIP) ? 8'h00 : hold_r[slot_r];
		merged = {hold_r[0], hold_r[1], hold_r[2]};
		case (slot_r)
			SLOT_RED: merged[23:16] = lane_byte;
			SLOT_GREEN: merged[15:8] = lane_byte;
			SLOT_BLUE: merged[7:0] = lane_byte;
			default: merged = {hold_r[0], hold_r[1], hold_r[2]};
		endcase
		if (lane_addr[3:0] == OFF_INDEX) begin
			rd_byte = reg_index_r;
		end else if (!is_data) begin
			rd_byte = 8'h00;
		end else if (reg_index_r == IDX_PAL_DATA) begin
			rd_byte = hold_sel;
		end else if (reg_index_r == IDX_SEQUENCE) begin
			rd_byte = {5'h00, order2_r, slot_r};
		end else if (reg_index_r == IDX_INDEX_LO || reg_index_r == IDX_PF_LO) begin
			rd_byte = idx_lo_r;
		end else if (reg_index_r == IDX_RED_HOLD) begin
			rd_byte = hold_r[0];
		end else if (reg_index_r == IDX_GREEN_HOLD) begin
			rd_byte = hold_r[1];
		end else if (reg_index_r == IDX_BLUE_HOLD) begin
			rd_byte = hold_r[2];
		end else if (in_bank) begin
			rd_byte = bank_r[bank_slot(reg_index_r)];
		end else begin
			rd_byte = 8'h00;
		end
		pix_addr = i_pixel[7:0] & bank_r[bank_slot(IDX_PAL_MASK)];
	end

	// Lane sequencer: one byte lane per enabled cycle, always four cycles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
			lane_r <= 2'h0;
			off_r <= 4'h0;
			be_r <= 4'h0;
			wd_r <= 32'h0000_0000;
			wr_r <= 1'b0;
			o_io_busy <= 1'b0;
			o_io_ack <= 1'b0;
		end else if (i_ce) begin
			o_io_ack <= 1'b0;
			if (take) begin
				state_r <= ST_LANE;
				lane_r <= 2'h0;
				off_r <= i_io_addr[3:0];
				be_r <= i_io_be;
				wd_r <= i_io_wdata;
				wr_r <= i_io_write;
				o_io_busy <= 1'b1;
			end else if (state_r == ST_LANE) begin
				lane_r <= lane_r + 2'h1;
				if (lane_r == 2'h3) begin
					state_r <= ST_IDLE;
					o_io_busy <= 1'b0;
					o_io_ack <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_io_rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			if (take) begin
				o_io_rdata <= 32'h0000_0000;
			end else if (lane_ok && !wr_r) begin
				o_io_rdata[{lane_r, 3'h0} +: 8] <= rd_byte;
			end
		end
	end

	// Low byte of a word write lands here, high byte goes to the data port
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			reg_index_r <= RESET_BYTE;
		end else if (i_ce && lane_ok && wr_r && lane_addr[3:0] == OFF_INDEX) begin
			reg_index_r <= lane_byte;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			slot_r <= SLOT_RED;
			order2_r <= 1'b0;
		end else if (i_ce) begin
			if (pal_wr || pal_rd) begin
				slot_r <= slot_nxt;
			end else if (pf_wr) begin
				slot_r <= SLOT_RED;
			end else if (ind_wr && reg_index_r == IDX_SEQUENCE) begin
				slot_r <= ppdc_slot_t'(lane_byte[1:0]);
				order2_r <= lane_byte[SEQ_ORDER_BIT];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			idx_lo_r <= RESET_BYTE;
		end else if (i_ce) begin
			if (pf_wr) begin
				idx_lo_r <= lane_byte + 8'h01;
			end else if ((pal_wr || pal_rd) && wrap) begin
				idx_lo_r <= idx_lo_r + 8'h01;
			end else if (ind_wr && reg_index_r == IDX_INDEX_LO) begin
				idx_lo_r <= lane_byte;
			end
		end
	end

	// Holding register; read refill and prefetch both reload all three fields
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < 3; i++) begin
				hold_r[i] <= RESET_BYTE;
			end
		end else if (i_ce) begin
			if (pf_wr) begin
				hold_r[0] <= pf_entry[23:16];
				hold_r[1] <= pf_entry[15:8];
				hold_r[2] <= pf_entry[7:0];
			end else if (pal_rd && wrap) begin
				hold_r[0] <= cur_entry[23:16];
				hold_r[1] <= cur_entry[15:8];
				hold_r[2] <= cur_entry[7:0];
			end else if (pal_wr) begin
				hold_r[0] <= merged[23:16];
				hold_r[1] <= merged[15:8];
				hold_r[2] <= merged[7:0];
			end else if (ind_wr && reg_index_r == IDX_RED_HOLD) begin
				hold_r[0] <= lane_byte;
			end else if (ind_wr && reg_index_r == IDX_GREEN_HOLD) begin
				hold_r[1] <= lane_byte;
			end else if (ind_wr && reg_index_r == IDX_BLUE_HOLD) begin
				hold_r[2] <= lane_byte;
			end
		end
	end

	// Palette contents are not reset; software loads every entry it uses
	always_ff @(posedge i_clk) begin
		if (i_ce && pal_wr && wrap) begin
			palette[idx_lo_r] <= merged;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < 32; i++) begin
				bank_r[i] <= RESET_BYTE;
			end
		end else if (i_ce && ind_wr && in_bank) begin
			bank_r[bank_slot(reg_index_r)] <= lane_byte;
		end
	end

	// Base variant cannot draw on wide pixels; narrow drawing is bytewise
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_draw_wide <= 1'b0;
		end else if (i_ce) begin
			o_draw_wide <= ENHANCED && bank_r[bank_slot(IDX_DRAW_CTRL)][DRAW_WIDE_BIT];
		end
	end

	ppdc_dac_fill #(
		.ENHANCED(ENHANCED)
	) u_dac_fill (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_direct(bank_r[bank_slot(IDX_DIRECT_CTRL)][DIRECT_EN_BIT]),
		.i_pixel(i_pixel),
		.i_pal_rgb(palette[pix_addr]),
		.i_fill(bank_r[bank_slot(IDX_DIRECT_CTRL)][FILL_LSB +: 2]),
		.i_blank_rb(bank_r[bank_slot(IDX_MISC_CTRL)][BLANK_RB_BIT]),
		.o_red(o_red),
		.o_green(o_green),
		.o_blue(o_blue)
	);

	chk_order1_restart: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pal_wr && !order2_r && slot_r == SLOT_BLUE)
		|=> (slot_r == SLOT_RED && palette[$past(idx_lo_r)] == $past(merged)))
		else $error("order one did not commit and restart");

	chk_order2_wait: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pal_wr && order2_r && slot_r == SLOT_BLUE)
		|=> (slot_r == SLOT_GREEN && idx_lo_r == $past(idx_lo_r)))
		else $error("order two committed too early");

	chk_commit_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pal_wr && wrap) |=> (idx_lo_r == $past(idx_lo_r) + 8'h01))
		else $error("index did not step after commit");

	chk_prefetch_load: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pf_wr) |=> ({hold_r[0], hold_r[1], hold_r[2]} == $past(pf_entry)
		&& idx_lo_r == $past(lane_byte) + 8'h01))
		else $error("prefetch did not load holding register");

	chk_read_field: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pal_rd) |=> (o_io_rdata[{$past(lane_r), 3'h0} +: 8] == $past(hold_sel)
		&& slot_r == $past(slot_nxt)))
		else $error("palette read returned wrong field");

	chk_read_refill: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pal_rd && wrap) |=> ({hold_r[0], hold_r[1], hold_r[2]} == $past(cur_entry)
		&& idx_lo_r == $past(idx_lo_r) + 8'h01))
		else $error("last field read did not refill");

	chk_foreign_port: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_io_req && state_r == ST_IDLE && !io_hit) |=> (state_r == ST_IDLE && !o_io_ack))
		else $error("foreign address accepted");

	chk_lane_count: assert property (@(posedge i_clk) disable iff (i_rst)
		(take ##1 i_ce [*4]) |=> (o_io_ack && !o_io_busy))
		else $error("access did not end after four lanes");

	chk_index_store: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && lane_ok && wr_r && lane_addr[3:0] == OFF_INDEX) ##1 (i_ce && ind_wr && in_bank)
		|=> (bank_r[bank_slot(reg_index_r)] == $past(lane_byte)))
		else $error("word write to index did not store data");
endmodule
`default_nettype wire

// [dv/ppdc_host_bfm.sv]
/*
 Host processor model: byte, word and string I/O cycles on the port.
 Assumes the port's one-cycle request strobe and a single ack pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module ppdc_host_bfm
	import ppdc_pkg::*;
#(
	parameter logic [3:0] INSTANCE = 4'h6
) (
	input wire logic i_clk,
	input wire logic i_ack,
	input wire logic [31:0] i_rdata,
	output logic o_req,
	output logic o_write,
	output logic [15:0] o_addr,
	output logic [3:0] o_be,
	output logic [31:0] o_wdata
);
	import ppdc_pkg::*;
	initial begin
		o_req = 1'b0;
		o_write = 1'b0;
		o_addr = 16'h0000;
		o_be = 4'h0;
		o_wdata = 32'h0000_0000;
	end
	// Drives on the falling edge; a miss simply waits out the bound
	task automatic io(input logic wr, input logic [3:0] off, input logic [3:0] be,
		input logic [31:0] wd, input bit hit, output logic [31:0] rd, output bit ok);
		int n;
		ok = 1'b0;
		rd = 32'h0000_0000;
		@(negedge i_clk);
		o_write = wr;
		o_addr = {IO_PAGE, hit ? INSTANCE : ~INSTANCE, off};
		o_be = be;
		o_wdata = wd;
		o_req = 1'b1;
		@(negedge i_clk);
		o_req = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge i_clk);
			#1;
			if (i_ack === 1'b1) begin
				ok = 1'b1;
				rd = i_rdata;
			end
		end
		// Released lines must not keep the old value
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
	task automatic preload_direct(input logic half_bit, output bit ok);
		logic [31:0] rd;
		logic [7:0] loc;
		bit ok1;
		int n;
		ok = 1'b1;
		io(1'b1, OFF_INDEX, 4'b0011, {16'h0000, half_bit, 7'h00, IDX_BORDER}, 1'b1, rd, ok1);
		ok = ok & ok1;
		io(1'b1, OFF_INDEX, 4'b0011, {16'h0000, 8'h00, IDX_SEQUENCE}, 1'b1, rd, ok1);
		ok = ok & ok1;
		loc = half_bit ? 8'h00 : 8'h80;
		io(1'b1, OFF_INDEX, 4'b0011, {16'h0000, loc, IDX_INDEX_LO}, 1'b1, rd, ok1);
		ok = ok & ok1;
		io(1'b1, OFF_INDEX, 4'b0001, {24'h00_0000, IDX_PAL_DATA}, 1'b1, rd, ok1);
		ok = ok & ok1;
		for (n = 0; n < 128; n++) begin
			// One byte per colour, blue steps by eight
			io(1'b1, OFF_DATA_FIRST, 4'b0111, {8'h00, n[4:0], 3'b000, 16'h0000}, 1'b1, rd, ok1);
			ok = ok & ok1;
		end
	endtask
endmodule
`default_nettype wire

// [dv/tb_palette_port_direct_color.sv]
/*
 Self-checking bench for the palette access port top.
 Assumes the host model drives the I/O port; pixels come from here.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_palette_port_direct_color;
	import ppdc_pkg::*;
	logic i_clk, i_rst, i_ce, req, wr, ack, busy, wide;
	logic [15:0] addr, i_pixel;
	logic [3:0] be;
	logic [31:0] wdata, rdata, rd, c, lanes;
	logic [7:0] o_red, o_green, o_blue, v, i;
	int miscompares, n_tests, k, f;
	integer seed;
	bit two, ok;
	ppdc_top #(.INSTANCE(4'h6), .ENHANCED(1'b1)) dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_ce(i_ce), .i_io_req(req), .i_io_write(wr), .i_io_addr(addr), .i_io_be(be),
		.i_io_wdata(wdata), .i_pixel(i_pixel), .o_io_rdata(rdata), .o_io_ack(ack),
		.o_io_busy(busy), .o_red(o_red), .o_green(o_green), .o_blue(o_blue),
		.o_draw_wide(wide));
	ppdc_host_bfm #(.INSTANCE(4'h6)) host (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata),
		.o_req(req), .o_write(wr), .o_addr(addr), .o_be(be), .o_wdata(wdata));
	always #4 i_clk = ~i_clk;
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] off, input logic [3:0] b,
		input logic [31:0] wd, output logic [31:0] r);
		bit hs;
		host.io(w, off, b, wd, 1'b1, r, hs);
		if (!hs) begin
			miscompares++;
			$display("CHECK FAILED io ack expected 1 seen 0");
			wrap_up();
		end
	endtask
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
		logic [31:0] r;
		xfer(1'b1, OFF_INDEX, 4'b0011, {16'h0000, val, idx}, r);
	endtask
	task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
		logic [31:0] r;
		xfer(1'b1, OFF_INDEX, 4'b0001, {24'h00_0000, idx}, r);
		xfer(1'b0, OFF_DATA_FIRST, 4'b0001, 32'h0000_0000, r);
		val = r[7:0];
	endtask
	// Converter inputs settle within a few cycles of a steady pixel
	task automatic pix(input logic [15:0] p, input logic [23:0] exp);
		@(negedge i_clk);
		i_pixel = p;
		repeat (4) @(negedge i_clk);
		check("colour out", 32'({o_red, o_green, o_blue}), 32'(exp));
	endtask
	function automatic logic [23:0] direct_exp(input logic [15:0] p, input logic [1:0] m);
		logic [4:0] r;
		logic [5:0] g;
		logic [4:0] b;
		r = p[15:11];
		g = p[10:5];
		b = p[4:0];
		case (m)
			2'd0: return {r, 3'b000, g, 2'b00, b, 3'b000};
			2'd1: return {r, 3'b111, g, 2'b11, b, 3'b111};
			2'd2: return {r, r[4:2], g, g[5:4], b, b[4:2]};
			default: return {r, {3{|r}}, g, {2{|g}}, b, {3{|b}}};
		endcase
	endfunction
	// Order two puts blue in the second slot and a dropped byte last
	function automatic logic [31:0] lanes_of(input logic [31:0] col, input bit ord2);
		return ord2 ? {col[31:24], col[15:8], col[23:16], col[7:0]} : {8'h00, col[23:0]};
	endfunction
	function automatic logic [7:0] shared_idx(input int n);
		case (n)
			0: return IDX_INDEX_LO;
			1: return IDX_INDEX_HI;
			2: return IDX_SEQUENCE;
			3: return IDX_RED_HOLD;
			4: return IDX_GREEN_HOLD;
			5: return IDX_BLUE_HOLD;
			default: return IDX_SPRITE_HOLD;
		endcase
	endfunction
	// Interrupting software saves these; prefetch indices stay out, they have side effects
	task automatic save_restore;
		logic [7:0] sv [0:6];
		logic [7:0] r;
		for (int n = 0; n < 7; n++) begin
			rd_reg(shared_idx(n), sv[n]);
		end
		wr_reg(IDX_PF_LO, 8'h05);
		wr_reg(IDX_SEQUENCE, 8'h06);
		for (int n = 0; n < 7; n++) begin
			wr_reg(shared_idx(n), sv[n]);
		end
		for (int n = 0; n < 7; n++) begin
			rd_reg(shared_idx(n), r);
			check("restored register", 32'(r), 32'(sv[n]));
		end
	endtask
	initial begin
		seed = 68;
		miscompares = 0;
		n_tests = 0;
		i_clk = 1'b0;
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_pixel = 16'h0000;
		repeat (8) @(negedge i_clk);
		i_rst = 1'b0;
		rd_reg(IDX_SEQUENCE, v);
		check("sequence at reset", 32'(v), 32'h0000_0000);
		i = 8'($random(seed));
		wr_reg(IDX_BORDER, i);
		xfer(1'b0, 4'hC, 4'b1111, 32'h0000_0000, rd);
		check("data ports", rd, {4{i}});
		xfer(1'b0, 4'h0, 4'b1111, 32'h0000_0000, rd);
		check("direct ports", rd, 32'h0000_0000);
		host.io(1'b1, OFF_INDEX, 4'b0011, {16'h0000, ~i, IDX_BORDER}, 1'b0, rd, ok);
		check("miss ack", 32'(ok), 32'h0000_0000);
		rd_reg(IDX_BORDER, v);
		check("border kept", 32'(v), 32'(i));
		for (k = 0; k < 6; k++) begin
			two = k[0];
			i = 8'($random(seed)) & 8'h7F;
			c = $random(seed);
			wr_reg(IDX_SEQUENCE, {5'b00000, two, 2'b00});
			wr_reg(IDX_INDEX_LO, i);
			xfer(1'b1, OFF_INDEX, 4'b0001, {24'h00_0000, IDX_PAL_DATA}, rd);
			xfer(1'b1, two ? 4'hC : 4'hB, two ? 4'b1111 : 4'b0111, lanes_of(c, two), rd);
			xfer(1'b1, two ? 4'hC : 4'hB, two ? 4'b1111 : 4'b0111, lanes_of(~c, two), rd);
			rd_reg(IDX_INDEX_LO, v);
			check("index after commits", 32'(v), 32'(i + 8'h02));
			rd_reg(IDX_SEQUENCE, v);
			check("sequence restart", 32'(v), {29'h0, two, 2'b00});
			wr_reg(IDX_PF_LO, i);
			rd_reg(IDX_INDEX_LO, v);
			check("index after prefetch", 32'(v), 32'(i + 8'h01));
			xfer(1'b1, OFF_INDEX, 4'b0001, {24'h00_0000, IDX_PAL_DATA}, rd);
			for (f = 0; f < 2; f++) begin
				lanes = lanes_of(f == 0 ? c : ~c, two);
				xfer(1'b0, two ? 4'hC : 4'hB, two ? 4'b1111 : 4'b0111, 32'h0000_0000, rd);
				check("palette readback", rd, {8'h00, lanes[23:0]});
			end
		end
		wr_reg(IDX_DIRECT_CTRL, 8'h00);
		wr_reg(IDX_MISC_CTRL, 8'h00);
		wr_reg(IDX_PAL_MASK, 8'h7F);
		pix({8'($random(seed)), i | 8'h80}, {c[7:0], c[15:8], c[23:16]});
		wr_reg(IDX_MISC_CTRL, 8'h01);
		pix({8'($random(seed)), i}, {8'h00, c[15:8], 8'h00});
		wr_reg(IDX_MISC_CTRL, 8'h00);
		for (f = 0; f < 4; f++) begin
			wr_reg(IDX_DIRECT_CTRL, {5'b00000, 1'b1, 2'(f)});
			c[15:0] = 16'($random(seed)) | 16'h0821;
			pix(c[15:0], direct_exp(c[15:0], 2'(f)));
		end
		// Clock enable low must freeze the converter outputs
		i_ce = 1'b0;
		pix(~c[15:0], direct_exp(c[15:0], 2'd3));
		i_ce = 1'b1;
		wr_reg(IDX_DRAW_CTRL, 8'h01);
		check("wide drawing", 32'(wide), 32'h0000_0001);
		wr_reg(IDX_DRAW_CTRL, 8'h00);
		check("bytewise drawing", 32'(wide), 32'h0000_0000);
		host.preload_direct(1'b0, ok);
		check("preload handshakes", 32'(ok), 32'h0000_0001);
		wr_reg(IDX_PF_LO, 8'h9A);
		xfer(1'b1, OFF_INDEX, 4'b0001, {24'h00_0000, IDX_PAL_DATA}, rd);
		xfer(1'b0, OFF_DATA_FIRST, 4'b0111, 32'h0000_0000, rd);
		check("preloaded entry", rd, 32'h00D0_0000);
		wr_reg(IDX_INDEX_HI, 8'($random(seed)));
		wr_reg(IDX_SPRITE_HOLD, 8'($random(seed)));
		save_restore();
		wrap_up();
	end
endmodule
`default_nettype wire
